// ==== hw/eoc_consts.vh ====
// constants for the external oscillator control block: offsets, fields, resets, counts
// assumes an 8-bit register port with byte offsets as printed
`ifndef EOC_CONSTS_VH
`define EOC_CONSTS_VH

// register offsets
`define EOC_OFF_LF_CTRL 8'h1C
`define EOC_OFF_HF_CTRL 8'h20
`define EOC_OFF_STATUS 8'h05

// reset values
`define EOC_RST_LF_CTRL 8'h00
`define EOC_RST_HF_CTRL 8'h00

// control fields, shared positions
`define EOC_BIT_ENABLE 0
`define EOC_BIT_ALWAYS_RUN 7
`define EOC_SU_HI 5
`define EOC_SU_LO 4
// low-frequency only
`define EOC_BIT_LF_LOW_POWER 1
`define EOC_BIT_LF_SOURCE 2
// high-frequency only
`define EOC_BIT_HF_SOURCE 1

// status fields
`define EOC_BIT_ST_LF_STABLE 4
`define EOC_BIT_ST_HF_STABLE 5
`define EOC_BIT_ST_LF_RUN 0
`define EOC_BIT_ST_HF_RUN 1
`define EOC_BIT_ST_LF_GRANT 2
`define EOC_BIT_ST_HF_GRANT 3

// start-up waits in oscillator cycles
`define EOC_LF_SU_0 65536'd0
`define EOC_LF_CYC_1K 1024
`define EOC_LF_CYC_16K 16384
`define EOC_LF_CYC_32K 32768
`define EOC_LF_CYC_64K 65536
`define EOC_HF_CYC_256 256
`define EOC_HF_CYC_1K 1024
`define EOC_HF_CYC_4K 4096
`define EOC_HF_SU_RESERVED 2'h3

// delivery latency in oscillator cycles once started
`define EOC_LF_DELIVER_CYC 3
`define EOC_HF_DELIVER_CYC 2

// sleep state codes
`define EOC_MODE_ACTIVE 2'h0
`define EOC_MODE_IDLE 2'h1
`define EOC_MODE_STANDBY 2'h2
`define EOC_MODE_POWERDOWN 2'h3

`endif

// ==== hw/eoc_startup.v ====
// start-up wait counter for one oscillator
// assumes osc_tick is a one-cycle pulse per oscillator cycle, synchronous to clk
`timescale 1ns/1ps
module eoc_startup #(
  parameter CW = 17
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // control
  input wire run,
  input wire crystal,
  input wire osc_tick,
  input wire [CW-1:0] target,
  // result
  output reg stable
);

  reg [CW-1:0] cnt;

  ////////////////////////////////////////////////////////////////////////////
  // a stopped oscillator loses its wait; an external clock needs no count
  always @(posedge clk) begin
    if (!rstn) begin
      cnt <= {CW{1'b0}};
      stable <= 1'b0;
    end else if (!run) begin
      cnt <= {CW{1'b0}};
      stable <= 1'b0;
    end else if (!stable) begin
      if (!crystal) begin
        stable <= 1'b1;
      end else if (osc_tick) begin
        if (cnt == target - {{(CW-1){1'b0}}, 1'b1}) begin
          stable <= 1'b1;
        end else begin
          cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // eoc_startup

// ==== hw/eoc_deliver.v ====
// delivery delay from request to granted clock, counted in oscillator cycles
// assumes osc_tick is a one-cycle pulse per oscillator cycle, synchronous to clk
`timescale 1ns/1ps
module eoc_deliver #(
  parameter N = 2
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // control
  input wire ready,
  input wire req,
  input wire osc_tick,
  // result
  output reg grant
);

  reg [3:0] cnt;

  ////////////////////////////////////////////////////////////////////////////
  // grant rises after N oscillator cycles of a started, requested clock
  always @(posedge clk) begin
    if (!rstn) begin
      cnt <= 4'h0;
      grant <= 1'b0;
    end else if (!(ready && req)) begin
      cnt <= 4'h0;
      grant <= 1'b0;
    end else if (!grant && osc_tick) begin
      if (cnt == N[3:0] - 4'h1) begin
        grant <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

endmodule // eoc_deliver

// ==== hw/eoc_top.v ====
// external oscillator control: low-frequency crystal/clock and high-frequency crystal/clock
// assumes synchronous oscillator tick pulses, a plain register port and a sleep-state input
//
// Notes on behaviour
// - lf crystal start-up codes 0..3 wait 1k, 16k, 32k, 64k cycles
// - lf start-up and source fields lock while enabled or stable
// - lf bit 2: 0 crystal on both pins, 1 external clock on pin a
// - lf bit 1 sets low-power mode; may lengthen crystal start-up
// - lf bit 0 enables oscillator and takes its pins from the port
// - hf always-run bit acts only while hf enable is 1
// - hf runs on request outside power-down, or always in active, idle, standby when always-run
// - requesters must tolerate start-up delay before using the clock
// - hf always-run: requested clock delivered after two hf cycles
// - hf crystal start-up codes 0..2 wait 256, 1K, 4K; code 3 reserved
// - hf start-up and source fields lock while enabled or stable
// - hf bit 1: 0 crystal on both pins, 1 external clock on pin a
// - hf bit 0 enables oscillator and takes its pins from the port
// - lf always-run keeps it on through power-down; delivery within three cycles
`timescale 1ns/1ps
`include "eoc_consts.vh"
module eoc_top #(
  parameter LF_CYC_1K = `EOC_LF_CYC_1K,
  parameter LF_CYC_16K = `EOC_LF_CYC_16K,
  parameter LF_CYC_32K = `EOC_LF_CYC_32K,
  parameter LF_CYC_64K = `EOC_LF_CYC_64K,
  parameter HF_CYC_256 = `EOC_HF_CYC_256,
  parameter HF_CYC_1K = `EOC_HF_CYC_1K,
  parameter HF_CYC_4K = `EOC_HF_CYC_4K
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  // sleep state of the device
  input wire [1:0] sleep_mode,
  // clock requests from peripherals or main clock selector
  input wire lf_req,
  input wire hf_req,
  output wire lf_grant,
  output wire hf_grant,
  // oscillator cycle pulses from the analog cells
  input wire lf_osc_tick,
  input wire hf_osc_tick,
  // analog oscillator controls
  output reg lf_osc_run,
  output reg lf_low_power,
  output reg lf_ext_clock,
  output reg hf_osc_run,
  output reg hf_ext_clock,
  // pin ownership, high takes pins from ordinary port control
  output reg lf_pin_override,
  output reg hf_pin_override,
  // stable flags as they appear in the main clock status
  output wire lf_stable_flag,
  output wire hf_stable_flag
);

  localparam CW = 17;

  // control registers
  reg [7:0] lf_ctrl;
  reg [7:0] hf_ctrl;
  reg [7:0] next_rdata;
  reg next_lf_run;
  reg next_hf_run;

  // decoded fields
  wire lf_en = lf_ctrl[`EOC_BIT_ENABLE];
  wire lf_always = lf_ctrl[`EOC_BIT_ALWAYS_RUN];
  wire [1:0] lf_startup_sel = lf_ctrl[`EOC_SU_HI:`EOC_SU_LO];
  wire lf_source_type = lf_ctrl[`EOC_BIT_LF_SOURCE];
  wire hf_en = hf_ctrl[`EOC_BIT_ENABLE];
  wire hf_always = hf_ctrl[`EOC_BIT_ALWAYS_RUN];
  wire [1:0] hf_startup_sel = hf_ctrl[`EOC_SU_HI:`EOC_SU_LO];
  wire hf_source_type = hf_ctrl[`EOC_BIT_HF_SOURCE];

  // locks on start-up and source fields
  wire lf_lock = lf_en | lf_stable_flag;
  wire hf_lock = hf_en | hf_stable_flag;

  wire wr_lf = wr_en && (addr == `EOC_OFF_LF_CTRL);
  wire wr_hf = wr_en && (addr == `EOC_OFF_HF_CTRL);

  reg [CW-1:0] lf_target;
  reg [CW-1:0] hf_target;

  //////////////////////////////////////////////////////////////////////////////
  // register writes; locked fields keep their value, the rest always write
  always @(posedge clk) begin
    if (!rstn) begin
      lf_ctrl <= `EOC_RST_LF_CTRL;
      hf_ctrl <= `EOC_RST_HF_CTRL;
    end else begin
      if (wr_lf) begin
        lf_ctrl[`EOC_BIT_ALWAYS_RUN] <= wdata[`EOC_BIT_ALWAYS_RUN];
        lf_ctrl[`EOC_BIT_LF_LOW_POWER] <= wdata[`EOC_BIT_LF_LOW_POWER];
        lf_ctrl[`EOC_BIT_ENABLE] <= wdata[`EOC_BIT_ENABLE];
        if (!lf_lock) begin
          lf_ctrl[`EOC_SU_HI:`EOC_SU_LO] <= wdata[`EOC_SU_HI:`EOC_SU_LO];
          lf_ctrl[`EOC_BIT_LF_SOURCE] <= wdata[`EOC_BIT_LF_SOURCE];
        end
      end
      if (wr_hf) begin
        hf_ctrl[`EOC_BIT_ALWAYS_RUN] <= wdata[`EOC_BIT_ALWAYS_RUN];
        hf_ctrl[`EOC_BIT_ENABLE] <= wdata[`EOC_BIT_ENABLE];
        if (!hf_lock) begin
          hf_ctrl[`EOC_SU_HI:`EOC_SU_LO] <= wdata[`EOC_SU_HI:`EOC_SU_LO];
          hf_ctrl[`EOC_BIT_HF_SOURCE] <= wdata[`EOC_BIT_HF_SOURCE];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // start-up targets; the reserved hf code falls back to the longest wait
  // so that a stray value never shortens the crystal's settling
  always @* begin
    case (lf_startup_sel)
      2'h0: lf_target = LF_CYC_1K[CW-1:0];
      2'h1: lf_target = LF_CYC_16K[CW-1:0];
      2'h2: lf_target = LF_CYC_32K[CW-1:0];
      default: lf_target = LF_CYC_64K[CW-1:0];
    endcase
    case (hf_startup_sel)
      2'h0: hf_target = HF_CYC_256[CW-1:0];
      2'h1: hf_target = HF_CYC_1K[CW-1:0];
      default: hf_target = HF_CYC_4K[CW-1:0];
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // run decision: enable gates everything, always-run covers every sleep state for lf, all but power-down for hf
  always @* begin
    next_lf_run = 1'b0;
    next_hf_run = 1'b0;
    if (lf_en) begin
      if (lf_always) begin
        next_lf_run = 1'b1;
      end else begin
        // on demand only while active or idle
        next_lf_run = lf_req && (sleep_mode == `EOC_MODE_ACTIVE || sleep_mode == `EOC_MODE_IDLE);
      end
    end
    if (hf_en) begin
      if (hf_always) begin
        next_hf_run = (sleep_mode != `EOC_MODE_POWERDOWN);
      end else begin
        next_hf_run = hf_req && (sleep_mode != `EOC_MODE_POWERDOWN);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog controls and pin ownership come from flops
  always @(posedge clk) begin
    if (!rstn) begin
      lf_osc_run <= 1'b0;
      hf_osc_run <= 1'b0;
      lf_low_power <= 1'b0;
      lf_ext_clock <= 1'b0;
      hf_ext_clock <= 1'b0;
      lf_pin_override <= 1'b0;
      hf_pin_override <= 1'b0;
    end else begin
      lf_osc_run <= next_lf_run;
      hf_osc_run <= next_hf_run;
      lf_low_power <= lf_ctrl[`EOC_BIT_LF_LOW_POWER];
      lf_ext_clock <= lf_source_type;
      hf_ext_clock <= hf_source_type;
      lf_pin_override <= lf_en;
      hf_pin_override <= hf_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // start-up counters, one per oscillator
  eoc_startup #(.CW(CW)) u_lf_startup (
    .clk(clk),
    .rstn(rstn),
    .run(lf_osc_run),
    .crystal(~lf_source_type),
    .osc_tick(lf_osc_tick),
    .target(lf_target),
    .stable(lf_stable_flag)
  );

  eoc_startup #(.CW(CW)) u_hf_startup (
    .clk(clk),
    .rstn(rstn),
    .run(hf_osc_run),
    .crystal(~hf_source_type),
    .osc_tick(hf_osc_tick),
    .target(hf_target),
    .stable(hf_stable_flag)
  );

  //////////////////////////////////////////////////////////////////////////////
  // clock delivery; grant waits for stable, so a requester never sees an
  // unsettled clock even though it is expected to allow for start-up
  eoc_deliver #(.N(`EOC_LF_DELIVER_CYC)) u_lf_deliver (
    .clk(clk),
    .rstn(rstn),
    .ready(lf_stable_flag),
    .req(lf_req),
    .osc_tick(lf_osc_tick),
    .grant(lf_grant)
  );

  eoc_deliver #(.N(`EOC_HF_DELIVER_CYC)) u_hf_deliver (
    .clk(clk),
    .rstn(rstn),
    .ready(hf_stable_flag),
    .req(hf_req),
    .osc_tick(hf_osc_tick),
    .grant(hf_grant)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read zero
  always @* begin
    next_rdata = 8'h00;
    case (addr)
      `EOC_OFF_LF_CTRL: next_rdata = lf_ctrl;
      `EOC_OFF_HF_CTRL: next_rdata = hf_ctrl;
      `EOC_OFF_STATUS: begin
        next_rdata[`EOC_BIT_ST_LF_STABLE] = lf_stable_flag;
        next_rdata[`EOC_BIT_ST_HF_STABLE] = hf_stable_flag;
        next_rdata[`EOC_BIT_ST_LF_RUN] = lf_osc_run;
        next_rdata[`EOC_BIT_ST_HF_RUN] = hf_osc_run;
        next_rdata[`EOC_BIT_ST_LF_GRANT] = lf_grant;
        next_rdata[`EOC_BIT_ST_HF_GRANT] = hf_grant;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // eoc_top

// ==== sim/eoc_top_assertions.sv ====
// checker for the external oscillator control block
// assumes it is bound to eoc_top and sees only its ports
`timescale 1ns/1ps
module eoc_top_chk (
  // clock and reset
  input wire clk,
  input wire rstn,
  // register port and sleep state
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire [1:0] sleep_mode,
  // requests, grants and ticks
  input wire lf_req,
  input wire lf_grant,
  input wire hf_grant,
  input wire lf_osc_tick,
  input wire hf_osc_tick,
  // oscillator controls and flags
  input wire lf_low_power,
  input wire lf_ext_clock,
  input wire hf_osc_run,
  input wire hf_ext_clock,
  input wire lf_pin_override,
  input wire hf_pin_override,
  input wire lf_stable_flag,
  input wire hf_stable_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // control bits reach the pins two cycles after the write
  property p_hf_en; wr_en && addr == 8'h20 |-> ##2 hf_pin_override == $past(wdata[0], 2); endproperty
  a_hf_en: assert property (p_hf_en) else $error("hf enable not applied");
  property p_lf_en; wr_en && addr == 8'h1C |-> ##2 lf_pin_override == $past(wdata[0], 2); endproperty
  a_lf_en: assert property (p_lf_en) else $error("lf enable not applied");
  property p_lf_lp; wr_en && addr == 8'h1C |-> ##2 lf_low_power == $past(wdata[1], 2); endproperty
  a_lf_lp: assert property (p_lf_lp) else $error("lf low power not applied");
  // running needs the enable; power-down stops the hf oscillator
  property p_hf_gate; hf_osc_run |-> hf_pin_override; endproperty
  a_hf_gate: assert property (p_hf_gate) else $error("hf runs while disabled");
  property p_hf_pd; sleep_mode == 2'h3 |=> !hf_osc_run; endproperty
  a_hf_pd: assert property (p_hf_pd) else $error("hf runs in power-down");
  property p_hf_stop; !hf_osc_run |=> !hf_stable_flag; endproperty
  a_hf_stop: assert property (p_hf_stop) else $error("hf stable while stopped");
  property p_hf_ext; $rose(hf_osc_run) && hf_ext_clock |=> hf_stable_flag; endproperty
  a_hf_ext: assert property (p_hf_ext) else $error("hf external clock not stable");
  // grants open only on an oscillator tick after start-up
  property p_hf_grant; $rose(hf_grant) |-> $past(hf_osc_tick) && $past(hf_stable_flag); endproperty
  a_hf_grant: assert property (p_hf_grant) else $error("hf grant off tick");
  property p_lf_grant; $rose(lf_grant) |-> $past(lf_osc_tick) && $past(lf_stable_flag) && $past(lf_req); endproperty
  a_lf_grant: assert property (p_lf_grant) else $error("lf grant off tick");
  // source select is frozen while enabled
  property p_lf_lock; $past(lf_pin_override) |-> $stable(lf_ext_clock); endproperty
  a_lf_lock: assert property (p_lf_lock) else $error("lf source changed while locked");
  property p_hf_lock; $past(hf_pin_override) |-> $stable(hf_ext_clock); endproperty
  a_hf_lock: assert property (p_hf_lock) else $error("hf source changed while locked");
  c_hf_grant: cover property ($rose(hf_grant));
  c_lf_grant: cover property ($rose(lf_grant));
  c_lf_lock: cover property (wr_en && addr == 8'h1C && lf_pin_override);
endmodule // eoc_top_chk
////////////////////////////////////////////////////////////////////////////
bind eoc_top eoc_top_chk i_chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .sleep_mode(sleep_mode), .lf_req(lf_req), .lf_grant(lf_grant), .hf_grant(hf_grant),
  .lf_osc_tick(lf_osc_tick), .hf_osc_tick(hf_osc_tick), .lf_low_power(lf_low_power),
  .lf_ext_clock(lf_ext_clock), .hf_osc_run(hf_osc_run), .hf_ext_clock(hf_ext_clock),
  .lf_pin_override(lf_pin_override), .hf_pin_override(hf_pin_override),
  .lf_stable_flag(lf_stable_flag), .hf_stable_flag(hf_stable_flag));

// ==== sim/eoc_osc_model.sv ====
// model of an external crystal or clock: one tick per oscillator cycle
// assumes the run input comes from the block's registered oscillator control
`timescale 1ns/1ps
module eoc_osc_model #(
  parameter int DIV = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // oscillator control and cycle pulse
  input wire logic run,
  output logic tick
);
  int cnt;
  // a stopped crystal gives no cycles, so the phase restarts on every power-up
  always @(posedge clk) begin
    if (!rstn || !run) begin
      cnt <= 0;
      tick <= 1'b0;
    end else begin
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
      tick <= (cnt == DIV - 1);
    end
  end
endmodule // eoc_osc_model

// ==== sim/tb_external_oscillator_control.sv ====
// self-checking bench for the external oscillator control block
// assumes shortened start-up counts and oscillator models on both tick inputs
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_external_oscillator_control;
  localparam int LF_T[4] = '{4, 8, 12, 16};
  localparam int HF_T[4] = '{3, 5, 7, 7};
  logic clk, rstn, wr_en, rd_en, lf_req, hf_req, lf_grant, hf_grant, lf_osc_tick, hf_osc_tick;
  logic lf_osc_run, lf_low_power, lf_ext_clock, hf_osc_run, hf_ext_clock;
  logic lf_pin_override, hf_pin_override, lf_stable_flag, hf_stable_flag;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] sleep_mode;
  int err_total = 0;
  int n_compared = 0;
  eoc_top #(.LF_CYC_1K(LF_T[0]), .LF_CYC_16K(LF_T[1]), .LF_CYC_32K(LF_T[2]), .LF_CYC_64K(LF_T[3]),
    .HF_CYC_256(HF_T[0]), .HF_CYC_1K(HF_T[1]), .HF_CYC_4K(HF_T[2])) i_dut (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sleep_mode(sleep_mode),
    .lf_req(lf_req), .hf_req(hf_req), .lf_grant(lf_grant), .hf_grant(hf_grant), .lf_osc_tick(lf_osc_tick),
    .hf_osc_tick(hf_osc_tick), .lf_osc_run(lf_osc_run), .lf_low_power(lf_low_power),
    .lf_ext_clock(lf_ext_clock), .hf_osc_run(hf_osc_run), .hf_ext_clock(hf_ext_clock),
    .lf_pin_override(lf_pin_override), .hf_pin_override(hf_pin_override),
    .lf_stable_flag(lf_stable_flag), .hf_stable_flag(hf_stable_flag));
  eoc_osc_model #(.DIV(3)) i_lf_osc (.clk(clk), .rstn(rstn), .run(lf_osc_run), .tick(lf_osc_tick));
  eoc_osc_model #(.DIV(2)) i_hf_osc (.clk(clk), .rstn(rstn), .run(hf_osc_run), .tick(hf_osc_tick));
  ////////////////////////////////////////////////////////////////////////////
  // each access starts on a fresh edge, so strobes never get two drivers in one step
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    `CHK(rdata, exp)
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // counts oscillator ticks seen before the stable flag rises
  task automatic su(input bit hf, output int n);
    n = 0;
    for (int k = 0; k < 400; k++) begin
      @(negedge clk);
      if ((hf ? hf_stable_flag : lf_stable_flag) === 1'b1) break;
      if ((hf ? hf_osc_tick : lf_osc_tick) === 1'b1) n++;
    end
  endtask
  task automatic wg(input bit hf);
    for (int k = 0; k < 60 && (hf ? hf_grant : lf_grant) !== 1'b1; k++) @(negedge clk);
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock and a watchdog far beyond the expected run
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #50us;
    err_total++;
    final_report();
  end
  // main sequence
  initial begin
    int n;
    {rstn, wr_en, rd_en, lf_req, hf_req, addr, wdata, sleep_mode} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h20, 8'h00);
    rd(8'h1C, 8'h00);
    rd(8'h3F, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h20, {2'h0, c[1:0], 4'h0});
      wr(8'h20, {2'h0, c[1:0], 4'h1});
      wt(4);
      `CHK(hf_osc_run, 1'b0)
      @(posedge clk);
      hf_req <= 1'b1;
      su(1, n);
      `CHK(n, HF_T[c])
      rd(8'h20, {2'h0, c[1:0], 4'h1});
      wr(8'h20, 8'h00);
      hf_req <= 1'b0;
      wt(3);
      `CHK({hf_osc_run, hf_stable_flag, hf_pin_override}, 3'b000)
      wr(8'h1C, {2'h0, c[1:0], 4'h2});
      wr(8'h1C, {2'h0, c[1:0], 4'h3});
      lf_req <= 1'b1;
      su(0, n);
      `CHK(n, LF_T[c])
      `CHK(lf_low_power, 1'b1)
      wr(8'h1C, {2'h0, ~c[1:0], 4'h7});
      rd(8'h1C, {2'h0, c[1:0], 4'h3});
      wr(8'h1C, 8'h00);
      lf_req <= 1'b0;
      wt(3);
    end
    wr(8'h20, 8'h02);
    wr(8'h20, 8'h03);
    hf_req <= 1'b1;
    wg(1);
    `CHK(hf_grant, 1'b1)
    `CHK(hf_ext_clock, 1'b1)
    wr(8'h20, 8'h01);
    rd(8'h20, 8'h03);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h2A);
    @(posedge clk);
    hf_req <= 1'b0;
    wr(8'h20, 8'h83);
    sleep_mode <= 2'h2;
    wt(4);
    `CHK(hf_osc_run, 1'b1)
    @(posedge clk);
    sleep_mode <= 2'h3;
    wt(4);
    `CHK(hf_osc_run, 1'b0)
    wr(8'h20, 8'h80);
    sleep_mode <= 2'h0;
    wt(4);
    `CHK(hf_osc_run, 1'b0)
    wr(8'h1C, 8'h81);
    sleep_mode <= 2'h3;
    wt(4);
    `CHK({lf_osc_run, lf_pin_override}, 2'b11)
    @(posedge clk);
    lf_req <= 1'b1;
    wg(0);
    `CHK(lf_grant, 1'b1)
    @(posedge clk);
    rstn <= 1'b0;
    wt(2);
    `CHK({lf_osc_run, lf_pin_override, lf_grant}, 3'b000)
    @(posedge clk);
    rstn <= 1'b1;
    rd(8'h1C, 8'h00);
    // external clock on the lf side: source bit reaches its pin control, no counted wait
    wr(8'h1C, 8'h04);
    wr(8'h1C, 8'h85);
    wt(3);
    `CHK({lf_ext_clock, lf_stable_flag, lf_pin_override}, 3'b111)
    rd(8'h1C, 8'h85);
    final_report();
  end
endmodule // tb_external_oscillator_control
